/* File: cse_card_model.sv */
// Card socket model: detect, status and ready pins plus card identification
`timescale 1ns/1ps
module cse_card_model (
    input wire logic clk,
    output logic card_status_pin,
    output logic detect_one_pin,
    output logic detect_two_pin,
    output logic ready_pin,
    output logic interrogating,
    output logic card_inserted,
    output cse_pkg::cse_card_s card_found
);
    // Empty socket: detect lines pulled high, status low, ready high
    initial
    begin
        card_status_pin = 1'b0;
        {detect_one_pin, detect_two_pin} = 2'h3;
        ready_pin = 1'b1;
        interrogating = 1'b0;
        card_inserted = 1'b0;
        card_found = '0;
    end
    // Card seated: detect lines fall while the bridge identifies it
    task automatic identify_start;
        interrogating = 1'b1;
        {detect_one_pin, detect_two_pin} = 2'h0;
    endtask
    // Report the card facts once, then scramble them so only the latch holds them
    task automatic identify_end(input logic cardbus, input logic [6:0] info);
        card_found = '{info: info, is_cardbus: cardbus, is_16bit: ~cardbus};
        card_inserted = 1'b1;
        @(negedge clk);
        card_inserted = 1'b0;
        interrogating = 1'b0;
        card_found = ~card_found;
    endtask
    task automatic set_status(input logic v);
        card_status_pin = v;
    endtask
endmodule

/* File: cse_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module cse_pin_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // Shift chain; first stage only feeds the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
        end
        else
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Accept a bit once the two later stages agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            level <= INIT;
        else
            for (int i = 0; i < WIDTH; i++)
                if (stage2[i] == stage3[i])
                    level[i] <= stage3[i];
    end
endmodule

/* File: cse_pkg.sv */
// Shared constants and types for the card socket status event block
package cse_pkg;
    // Socket window word offsets (byte addresses)
    localparam logic [5:0] OFS_EVENTS = 6'h00;
    localparam logic [5:0] OFS_MASK = 6'h04;
    localparam logic [5:0] OFS_STATE = 6'h08;
    localparam logic [5:0] OFS_FORCE = 6'h0C;
    // Event and mask field positions
    localparam int EV_CARD_STATUS = 0;
    localparam int EV_DETECT_ONE = 1;
    localparam int EV_DETECT_TWO = 2;
    localparam int EV_POWER = 3;
    localparam int EV_WIDTH = 4;
    localparam logic [1:0] DETECT_EN_ON = 2'h3;
    // Present-state field positions
    localparam int ST_CARD_STATUS = 0;
    localparam int ST_DETECT_ONE = 1;
    localparam int ST_DETECT_TWO = 2;
    localparam int ST_POWERED = 3;
    localparam int ST_IS_16BIT = 4;
    localparam int ST_IS_CARDBUS = 5;
    localparam int ST_READY = 6;
    localparam int ST_INFO_LO = 7;
    localparam int ST_INFO_HI = 13;
    localparam int ST_CAPS_LO = 28;
    localparam int ST_CAPS_HI = 31;
    // Reset values
    localparam logic [3:0] CAPS_RESET = 4'h3;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [3:0] EVENTS_RESET = 4'h0;
    localparam logic [2:0] PIN_RESET = 3'h6;
    localparam int PIN_COUNT = 3;

    // One access from the socket window decode
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cse_req_s;

    // Card facts found by interrogation
    typedef struct packed {
        logic [6:0] info;
        logic is_cardbus;
        logic is_16bit;
    } cse_card_s;
endpackage

/* File: cse_socket_events.sv */
// Socket status-change event, mask and present-state registers
// Behaviour
// R1: Event register bits 31 to 4 always read as zero.
// R2: Power-cycle event bit 3 sets on any powered-state change; write 1 clears.
// R3: Detect-two event bit 2 sets on detect-two state change; write 1 clears.
// R4: Detect-one event bit 1 sets on detect-one state change; write 1 clears.
// R5: CardBus card: card status event sets on rising status edge only; write 1 clears.
// R6: 16-bit card: card status event sets on both status edges.
// R7: Mask only gates the interrupt; events still set when masked.
// R8: Mask bits 31 to 4 read zero and ignore writes.
// R9: Mask bit 3 enables power-cycle interrupt; resets to 0.
// R10: Detect mask field 11 enables, 00 blocks; 01 and 10 undefined.
// R11: Mask bit 0 enables card status interrupt; resets to 0.
// R12: Present-state at 08h read-only; resets to 3000_00XX with live bits.
// R13: Force-event writes show in present-state alongside live socket status.
// R14: Card voltage and type fields update only on insertion, else hold. Here force writes to 0Ch also load them.
// R15: During interrogation detect bits freeze, so no detect events.
// R16: Event register at 00h, cleared by reset, set by force writes.
// R17: Software clears pending events before enabling the interrupt.
// R18: Interrupt high while any enabled event bit is set.
// R19: A new change in the clearing cycle keeps the event bit set.
`timescale 1ns/1ps
module cse_socket_events (
    input wire logic clk,
    input wire logic rst_n,
    input cse_pkg::cse_req_s req,
    output logic [31:0] rdata,
    output logic rvalid,
    input wire logic card_status_pin,
    input wire logic detect_one_pin,
    input wire logic detect_two_pin,
    input wire logic ready_pin,
    input wire logic socket_powered,
    input wire logic interrogating,
    input wire logic card_inserted,
    input cse_pkg::cse_card_s card_found,
    output logic status_change_interrupt
);
    logic [2:0] pin_level;
    logic ready_level;
    logic card_status_level;
    logic detect_one_level;
    logic detect_two_level;
    logic powered_level;
    logic [3:0] events;
    logic [3:0] next_events;
    logic [3:0] mask;
    logic [3:0] caps;
    logic [6:0] card_info;
    logic is_cardbus;
    logic is_16bit;
    logic [3:0] seen;
    logic [3:0] change;
    logic [3:0] clear;
    logic [3:0] force_set;
    logic [3:0] enabled;
    logic [31:0] state_word;
    logic wr_lo;
    logic wr_hi;
    logic hit_events;
    logic hit_mask;
    logic hit_force;
    logic hit_state;

    // True when the access addresses the given window offset
    function automatic logic addr_hit(input cse_pkg::cse_req_s r, input logic [5:0] ofs);
        addr_hit = r.addr == ofs;
    endfunction

    // Live socket pins through the synchroniser
    cse_pin_sync #(
        .WIDTH(cse_pkg::PIN_COUNT),
        .INIT(cse_pkg::PIN_RESET)
    ) u_pins (
        .clk(clk),
        .rst_n(rst_n),
        .pin({detect_two_pin, detect_one_pin, card_status_pin}),
        .level(pin_level)
    );

    cse_pin_sync #(
        .WIDTH(1),
        .INIT(1'h0)
    ) u_ready (
        .clk(clk),
        .rst_n(rst_n),
        .pin(ready_pin),
        .level(ready_level)
    );

    assign card_status_level = pin_level[0];
    assign powered_level = socket_powered;

    // Detect levels held while the lines are used for identification
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            detect_one_level <= 1'h1;
            detect_two_level <= 1'h1;
        end
        else if (!interrogating) // R15
        begin
            detect_one_level <= pin_level[1];
            detect_two_level <= pin_level[2];
        end
    end

    // Byte lanes of the access
    assign wr_lo = req.wr && req.be[0];
    assign wr_hi = req.wr && req.be[3];

    // Offset decode shared by every register
    assign hit_events = addr_hit(req, cse_pkg::OFS_EVENTS);
    assign hit_mask = addr_hit(req, cse_pkg::OFS_MASK);
    assign hit_force = addr_hit(req, cse_pkg::OFS_FORCE);
    assign hit_state = addr_hit(req, cse_pkg::OFS_STATE);

    // Card facts latched on insertion or forced by software
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            caps <= cse_pkg::CAPS_RESET; // R12
            card_info <= 7'h00;
            is_cardbus <= 1'h0;
            is_16bit <= 1'h0;
        end
        else
        begin
            if (wr_hi && hit_force)
                caps <= req.wdata[cse_pkg::ST_CAPS_HI:cse_pkg::ST_CAPS_LO]; // R13
            if (req.wr && req.be[1] && req.be[0] && hit_force)
            begin
                card_info <= req.wdata[cse_pkg::ST_INFO_HI:cse_pkg::ST_INFO_LO]; // R13
                is_cardbus <= req.wdata[cse_pkg::ST_IS_CARDBUS];
                is_16bit <= req.wdata[cse_pkg::ST_IS_16BIT];
            end
            else if (card_inserted) // R14
            begin
                card_info <= card_found.info;
                is_cardbus <= card_found.is_cardbus;
                is_16bit <= card_found.is_16bit;
            end
        end
    end

    // Present-state word; reserved bits 27 to 14 are zero
    always_comb
    begin
        state_word = 32'h0000_0000;
        state_word[cse_pkg::ST_CAPS_HI:cse_pkg::ST_CAPS_LO] = caps; // R12
        state_word[cse_pkg::ST_INFO_HI:cse_pkg::ST_INFO_LO] = card_info;
        state_word[cse_pkg::ST_READY] = ready_level;
        state_word[cse_pkg::ST_IS_CARDBUS] = is_cardbus;
        state_word[cse_pkg::ST_IS_16BIT] = is_16bit;
        state_word[cse_pkg::ST_POWERED] = powered_level;
        state_word[cse_pkg::ST_DETECT_TWO] = detect_two_level;
        state_word[cse_pkg::ST_DETECT_ONE] = detect_one_level;
        state_word[cse_pkg::ST_CARD_STATUS] = card_status_level;
    end

    // Previous levels of the watched present-state bits
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            seen <= {1'h0, 2'h3, 1'h0};
        else
            seen <= state_word[3:0];
    end

    // Change detection per event source
    always_comb
    begin
        change = state_word[3:0] ^ seen; // R2 R3 R4
        if (is_cardbus)
            change[cse_pkg::EV_CARD_STATUS] = card_status_level && !seen[0]; // R5
        else
            change[cse_pkg::EV_CARD_STATUS] = card_status_level != seen[0]; // R6
    end

    assign clear = (wr_lo && hit_events) ? req.wdata[3:0] : 4'h0;
    assign force_set = (wr_lo && hit_force) ? req.wdata[3:0] : 4'h0; // R16
    // Set wins over clear; mask plays no part here
    assign next_events = (events & ~clear) | change | force_set; // R19 R7

    // Sticky event bits
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            events <= cse_pkg::EVENTS_RESET; // R16
        else
            events <= next_events; // R2 R3 R4 R5
    end

    // Mask register, low nibble only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mask <= cse_pkg::MASK_RESET; // R9 R11
        else if (wr_lo && hit_mask)
            mask <= req.wdata[3:0]; // R8
    end

    // Interrupt enables; reserved detect codes block
    always_comb
    begin
        enabled = 4'h0;
        enabled[cse_pkg::EV_POWER] = mask[3]; // R9
        enabled[cse_pkg::EV_DETECT_TWO] = mask[2:1] == cse_pkg::DETECT_EN_ON; // R10
        enabled[cse_pkg::EV_DETECT_ONE] = mask[2:1] == cse_pkg::DETECT_EN_ON;
        enabled[cse_pkg::EV_CARD_STATUS] = mask[0]; // R11
    end

    // Level request from enabled pending events
    assign status_change_interrupt = |(events & enabled); // R18

    // Read data registered one cycle after the request
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= 32'h0000_0000;
            rvalid <= 1'h0;
        end
        else
        begin
            rvalid <= req.rd;
            if (req.rd)
            begin
                unique case (req.addr)
                    cse_pkg::OFS_EVENTS: rdata <= {28'h0000000, events}; // R1
                    cse_pkg::OFS_MASK: rdata <= {28'h0000000, mask}; // R8
                    cse_pkg::OFS_STATE: rdata <= state_word; // R12
                    default: rdata <= 32'h0000_0000; // Force register is write-only
                endcase
            end
        end
    end

    // Checks on the event and mask logic
    a_evt_upper_zero: assert property (@(posedge clk) disable iff (!rst_n) // R1
        req.rd && req.addr == cse_pkg::OFS_EVENTS |=> rvalid && rdata[31:4] == 28'h0000000)
        else $error("event upper bits not zero");
    a_power_evt_set: assert property (@(posedge clk) disable iff (!rst_n) // R2
        powered_level != seen[3] |=> events[3])
        else $error("power event missed");
    a_det_two_evt: assert property (@(posedge clk) disable iff (!rst_n) // R3
        $changed(detect_two_level) |=> events[2])
        else $error("detect two event missed");
    a_det_one_evt: assert property (@(posedge clk) disable iff (!rst_n) // R4
        $changed(detect_one_level) |=> events[1])
        else $error("detect one event missed");
    a_cb_no_fall: assert property (@(posedge clk) disable iff (!rst_n) // R5
        is_cardbus && !card_status_level && seen[0] && !events[0] && force_set[0] == 1'h0
        |=> !events[0])
        else $error("cardbus falling edge set event");
    a_bit16_fall_set: assert property (@(posedge clk) disable iff (!rst_n) // R6
        !is_cardbus && !card_status_level && seen[0] |=> events[0])
        else $error("16-bit falling edge missed");
    a_mask_upper_zero: assert property (@(posedge clk) disable iff (!rst_n) // R8
        req.rd && req.addr == cse_pkg::OFS_MASK |=> rdata[31:4] == 28'h0000000)
        else $error("mask upper bits not zero");
    a_detect_frozen: assert property (@(posedge clk) disable iff (!rst_n) // R15
        interrogating |=> $stable(detect_one_level) && $stable(detect_two_level))
        else $error("detect bits moved during interrogation");
    a_info_hold: assert property (@(posedge clk) disable iff (!rst_n) // R14
        !card_inserted && !(req.wr && req.addr == cse_pkg::OFS_FORCE) |=> $stable(card_info) && $stable(is_cardbus))
        else $error("card facts changed between insertions");
    a_irq_enabled: assert property (@(posedge clk) disable iff (!rst_n) // R18
        events[3] && mask[3] |-> status_change_interrupt)
        else $error("enabled event without interrupt");
    a_irq_detect_code: assert property (@(posedge clk) disable iff (!rst_n) // R10
        mask == 4'h6 && events[1] |-> status_change_interrupt)
        else $error("detect mask 11 did not enable");
    a_set_wins: assert property (@(posedge clk) disable iff (!rst_n) // R19
        clear[3] && powered_level != seen[3] |=> events[3])
        else $error("clear beat a new change");
    a_clear_works: assert property (@(posedge clk) disable iff (!rst_n) // R3
        clear[2] && !change[2] && !force_set[2] |=> !events[2])
        else $error("write one did not clear");

    // Clearing, masking, latching and read-back checks
    a_power_clear: assert property (@(posedge clk) disable iff (!rst_n) // R2
        clear[3] && !change[3] && !force_set[3] |=> !events[3])
        else $error("power event not cleared");
    a_det_one_clear: assert property (@(posedge clk) disable iff (!rst_n) // R4
        clear[1] && !change[1] && !force_set[1] |=> !events[1])
        else $error("detect one event not cleared");
    a_status_clear: assert property (@(posedge clk) disable iff (!rst_n) // R5
        clear[0] && !change[0] && !force_set[0] |=> !events[0])
        else $error("card status event not cleared");
    a_cb_rise_set: assert property (@(posedge clk) disable iff (!rst_n) // R5
        is_cardbus && card_status_level && !seen[0] |=> events[0])
        else $error("cardbus rising edge missed");
    a_masked_still_set: assert property (@(posedge clk) disable iff (!rst_n) // R7
        mask == 4'h0 && change[1] |=> events[1])
        else $error("masked detect event not recorded");
    a_irq_blocked: assert property (@(posedge clk) disable iff (!rst_n) // R7
        mask == 4'h0 |-> !status_change_interrupt)
        else $error("interrupt with all events masked");
    a_mask_hold: assert property (@(posedge clk) disable iff (!rst_n) // R8
        !(wr_lo && hit_mask) |=> $stable(mask))
        else $error("mask changed without a write");
    a_mask_write: assert property (@(posedge clk) disable iff (!rst_n) // R9
        wr_lo && hit_mask |=> mask == $past(req.wdata[3:0]))
        else $error("mask write not taken");
    a_irq_detect_block: assert property (@(posedge clk) disable iff (!rst_n) // R10
        mask == 4'h2 |-> !status_change_interrupt)
        else $error("reserved detect code raised interrupt");
    a_irq_status: assert property (@(posedge clk) disable iff (!rst_n) // R11
        events[0] && mask[0] |-> status_change_interrupt)
        else $error("card status event without interrupt");
    a_state_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n) // R12
        req.rd && hit_state |=> rdata[27:14] == 14'h0)
        else $error("present state reserved bits not zero");
    a_state_caps: assert property (@(posedge clk) disable iff (!rst_n) // R12
        req.rd && hit_state |=> rdata[31:28] == $past(caps))
        else $error("present state caps field wrong");
    a_caps_hold: assert property (@(posedge clk) disable iff (!rst_n) // R13
        !(wr_hi && hit_force) |=> $stable(caps))
        else $error("caps changed without a force write");
    a_force_info: assert property (@(posedge clk) disable iff (!rst_n) // R13
        req.wr && req.be[1] && req.be[0] && hit_force
        |=> card_info == $past(req.wdata[cse_pkg::ST_INFO_HI:cse_pkg::ST_INFO_LO]))
        else $error("forced card facts not taken");
    a_info_latch: assert property (@(posedge clk) disable iff (!rst_n) // R14
        card_inserted && !(req.wr && req.be[1] && req.be[0] && hit_force)
        |=> card_info == $past(card_found.info) && is_cardbus == $past(card_found.is_cardbus))
        else $error("card facts not latched on insertion");
    a_detect_no_evt: assert property (@(posedge clk) disable iff (!rst_n) // R15
        interrogating && $past(interrogating) |-> !change[1] && !change[2])
        else $error("detect change seen during interrogation");
    a_force_sets: assert property (@(posedge clk) disable iff (!rst_n) // R16
        |force_set |=> (events & $past(force_set)) == $past(force_set))
        else $error("forced event not set");
    a_evt_read: assert property (@(posedge clk) disable iff (!rst_n) // R16
        req.rd && hit_events |=> rdata[3:0] == $past(events))
        else $error("event read data wrong");
    a_irq_idle: assert property (@(posedge clk) disable iff (!rst_n) // R18
        events == 4'h0 |-> !status_change_interrupt)
        else $error("interrupt without a pending event");

    c_power_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(status_change_interrupt) && events[3]);
    c_cb_rise: cover property (@(posedge clk) disable iff (!rst_n) is_cardbus && $rose(events[0]));
    c_set_clear: cover property (@(posedge clk) disable iff (!rst_n) |(clear & change));
    c_interrogate: cover property (@(posedge clk) disable iff (!rst_n) interrogating && $changed(pin_level[1]));
    c_bit16_fall: cover property (@(posedge clk) disable iff (!rst_n) !is_cardbus && change[0] && !card_status_level);
endmodule

/* File: test_card_socket_status_events.sv */
// Self-checking testbench for the socket status event block
`timescale 1ns/1ps
module test_card_socket_status_events;
    typedef struct packed {logic [5:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] e;} cse_row_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pwr = 1'b0;
    cse_pkg::cse_req_s req = '0;
    logic [31:0] rdata;
    logic rvalid;
    logic cs, d1, d2, rdy, intg, ins, irq;
    cse_pkg::cse_card_s found;
    logic [31:0] got;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    // Write then read back: mask, read-only, force, unmapped and event places
    cse_row_s rows[7] = '{
        '{6'h04, 4'hF, 32'hFFFF_FFFF, 32'h0000_000F},
        '{6'h04, 4'hF, 32'h0000_0009, 32'h0000_0009},
        '{6'h04, 4'hF, 32'h0000_0000, 32'h0000_0000},
        '{6'h08, 4'hF, 32'hFFFF_FFFF, 32'h3000_0046},
        '{6'h0C, 4'h0, 32'hFFFF_FFFF, 32'h0000_0000},
        '{6'h10, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000},
        '{6'h00, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}};

    cse_socket_events u_dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
        .card_status_pin(cs), .detect_one_pin(d1), .detect_two_pin(d2), .ready_pin(rdy),
        .socket_powered(pwr), .interrogating(intg), .card_inserted(ins), .card_found(found),
        .status_change_interrupt(irq));
    cse_card_model u_card (.clk(clk), .card_status_pin(cs), .detect_one_pin(d1), .detect_two_pin(d2),
        .ready_pin(rdy), .interrogating(intg), .card_inserted(ins), .card_found(found));

    // Free-running 200 MHz clock
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic complete_run;
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One write cycle, then a quiet cycle so strobes never collide
    task automatic wr(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
        @(negedge clk);
        req = '0;
        @(negedge clk);
    endtask

    // Read cycle; data is taken while the one-cycle valid stands
    task automatic rd(input logic [5:0] a);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'h0, wdata: 32'h0};
        @(negedge clk);
        req = '0;
        got = (rvalid === 1'b1) ? rdata : 32'hFFFF_FFFF;
        @(negedge clk);
    endtask

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            complete_run();
        end
    end

    initial
    begin
        idle(5);
        rst_n = 1'b1;
        idle(8);
        rd(6'h00);
        check("events reset", got, 32'h0);
        rd(6'h04);
        check("mask reset", got, 32'h0);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].be, rows[i].d);
            rd(rows[i].a);
            check("table read", got, rows[i].e);
        end
        // Power cycle event, masked then enabled with the event still pending
        pwr = 1'b1;
        idle(2);
        rd(6'h00);
        check("power event", got, 32'h8);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(6'h04, 4'hF, 32'h8);
        check("irq power", {31'h0, irq}, 32'h1);
        wr(6'h00, 4'hF, 32'h8);
        check("irq cleared", {31'h0, irq}, 32'h0);
        // Detect changes held back during identification
        wr(6'h04, 4'hF, 32'h0);
        u_card.identify_start();
        idle(12);
        rd(6'h00);
        check("frozen detect", got, 32'h0);
        u_card.identify_end(1'b1, 7'h55);
        idle(12);
        rd(6'h00);
        check("detect events", got, 32'h6);
        rd(6'h08);
        check("present card", got, 32'h3000_2AE8);
        wr(6'h04, 4'hF, 32'h6);
        check("irq detect on", {31'h0, irq}, 32'h1);
        wr(6'h04, 4'hF, 32'h2);
        check("irq detect 01", {31'h0, irq}, 32'h0);
        wr(6'h00, 4'hF, 32'h6);
        // CardBus card: only the rising status edge counts
        wr(6'h04, 4'hF, 32'h1);
        u_card.set_status(1'b1);
        idle(10);
        check("irq status", {31'h0, irq}, 32'h1);
        wr(6'h00, 4'hF, 32'h1);
        u_card.set_status(1'b0);
        idle(10);
        rd(6'h00);
        check("cardbus fall", got, 32'h0);
        // 16-bit card: the falling edge counts too
        u_card.identify_start();
        u_card.identify_end(1'b0, 7'h00);
        u_card.set_status(1'b1);
        idle(10);
        wr(6'h00, 4'hF, 32'h1);
        u_card.set_status(1'b0);
        idle(10);
        rd(6'h00);
        check("16bit fall", got, 32'h1);
        // Force register sets events and overrides capabilities
        wr(6'h0C, 4'h3, 32'h0000_2A8F);
        rd(6'h00);
        check("forced events", got, 32'hF);
        wr(6'h0C, 4'h8, 32'h5000_0000);
        rd(6'h08);
        check("forced caps", got, 32'h5000_2AC8);
        // Clear landing with a power change keeps the power event
        pwr = 1'b0;
        wr(6'h00, 4'h1, 32'h0000_000F);
        rd(6'h00);
        check("set wins", got, 32'h8);
        // Reset in mid-run clears pending events
        rst_n = 1'b0;
        idle(1);
        rst_n = 1'b1;
        rd(6'h00);
        check("events rereset", got, 32'h0);
        complete_run();
    end
endmodule
